// ### rtl/vic_pkg.sv
// Shared constants and types for the vectored interrupt controller
package vic_pkg;

  localparam int NUM_MASKABLE = 18;
  localparam int IDX_W = 5;
  localparam int NUM_EXT_PINS = 4;
  localparam int NUM_KEY_PINS = 8;
  localparam int APB_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_PRIO = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_EDGE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Reset values
  localparam logic [17:0] REQ_RESET = 18'h00000;
  localparam logic [17:0] MASK_RESET = 18'h3ffff;
  localparam logic [17:0] PRIO_RESET = 18'h3ffff;
  localparam logic CTRL_IE_RESET = 1'b0;
  localparam logic CTRL_ISP_RESET = 1'b1;
  localparam logic CTRL_WDT_NMI_RESET = 1'b1;
  localparam logic [3:0] EDGE_RESET = 4'h0;

  // Control register fields
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_ISP_BIT = 1;
  localparam int CTRL_WDT_NMI_BIT = 2;

  // Edge register fields
  localparam int EDGE_RISE_LSB = 0;
  localparam int EDGE_FALL_LSB = 4;

  // Status register fields
  localparam int STAT_INDEX_LSB = 0;
  localparam int STAT_MASKABLE_BIT = 8;
  localparam int STAT_NMI_BIT = 9;
  localparam int STAT_TRAP_BIT = 10;
  localparam int STAT_KIND_LSB = 12;

  // Vector addresses of maskable sources; entry 0 is replaced by a parameter
  localparam logic [15:0] VECTOR_TABLE [NUM_MASKABLE] = '{
    16'h0000, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h001a, 16'h001c,
    16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028};
  localparam logic [15:0] VECTOR_TRAP = 16'h003e;

  typedef enum logic [1:0] {KIND_NONE, KIND_NMI, KIND_MASKABLE, KIND_TRAP} int_kind_t;

endpackage

// ### rtl/irq_sel_if.sv
// Connection between flag store and priority resolver
`timescale 1ns/1ps
interface irq_sel_if import vic_pkg::*; ();
  logic [NUM_MASKABLE-1:0] req;
  logic [NUM_MASKABLE-1:0] mask;
  logic [NUM_MASKABLE-1:0] prio;
  logic ie;
  logic in_service_level_flag;
  logic valid;
  logic [IDX_W-1:0] index;

  modport owner (output req, output mask, output prio, output ie, output in_service_level_flag,
                 input valid, input index);
  modport resolver (input req, input mask, input prio, input ie, input in_service_level_flag,
                    output valid, output index);
endinterface

// ### rtl/irq_priority_resolver.sv
// Picks the winning maskable request
`timescale 1ns/1ps
module irq_priority_resolver import vic_pkg::*; (
  // Flags in, winner out
  irq_sel_if.resolver sel
);

  logic [NUM_MASKABLE-1:0] eligible;
  logic [NUM_MASKABLE-1:0] high;
  logic [NUM_MASKABLE-1:0] pool;

  always_comb begin
    // Unmasked, globally enabled, and allowed by the in-service level
    eligible = sel.req & ~sel.mask & {NUM_MASKABLE{sel.ie}}
               & (~sel.prio | {NUM_MASKABLE{sel.in_service_level_flag}});
    high = eligible & ~sel.prio;
    pool = (|high) ? high : eligible;
    sel.valid = |pool;
    sel.index = '0;
    // Lowest index wins within a level
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (pool[i]) begin
        sel.index = IDX_W'(i);
      end
    end
  end

endmodule

// ### rtl/vectored_interrupt_controller.sv
// Vectored interrupt controller with APB register access
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module vectored_interrupt_controller import vic_pkg::*; #(
  parameter logic [15:0] WDT_VECTOR = 16'h0004
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Source events
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic [NUM_EXT_PINS-1:0] EXT_PIN,
  input wire logic ASYNC_RX_ERROR,
  input wire logic ASYNC_RX_DONE,
  input wire logic ASYNC_TX_DONE,
  input wire logic THREE_WIRE_DONE,
  input wire logic TWO_WIRE_DONE,
  input wire logic WATCH_INTERVAL,
  input wire logic [1:0] TIMER16_MATCH,
  input wire logic TIMER8A_MATCH,
  input wire logic TIMER8B_MATCH,
  input wire logic ADC_DONE,
  input wire logic WATCH_OVERFLOW,
  input wire logic [NUM_KEY_PINS-1:0] KEY_PIN,
  // CPU core side
  input wire logic SOFTWARE_TRAP_INSTRUCTION,
  input wire logic INT_ACK,
  input wire logic INT_RETURN,
  input wire logic RESTORE_IE,
  input wire logic RESTORE_ISP,
  output logic INT_REQ,
  output logic [15:0] INT_VECTOR,
  output logic [1:0] INT_KIND,
  output logic GLOBAL_ENABLE
);

  irq_sel_if sel ();

  // Flag state
  logic [NUM_MASKABLE-1:0] req_reg;
  logic [NUM_MASKABLE-1:0] req_next;
  logic [NUM_MASKABLE-1:0] mask_reg;
  logic [NUM_MASKABLE-1:0] mask_next;
  logic [NUM_MASKABLE-1:0] prio_reg;
  logic [NUM_MASKABLE-1:0] prio_next;
  logic global_enable_flag_reg;
  logic global_enable_flag_next;
  logic in_service_level_flag_reg;
  logic in_service_level_flag_next;
  logic wdt_nmi_reg;
  logic wdt_nmi_next;
  logic nmi_pend_reg;
  logic nmi_pend_next;
  logic trap_pend_reg;
  logic trap_pend_next;
  logic [NUM_EXT_PINS-1:0] rise_en_reg;
  logic [NUM_EXT_PINS-1:0] rise_en_next;
  logic [NUM_EXT_PINS-1:0] fall_en_reg;
  logic [NUM_EXT_PINS-1:0] fall_en_next;
  logic [NUM_EXT_PINS-1:0] ext_prev_reg;
  logic [NUM_KEY_PINS-1:0] key_prev_reg;

  // APB state
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // CPU output state
  logic int_req_reg;
  logic int_req_next;
  logic [15:0] int_vector_reg;
  logic [15:0] int_vector_next;
  int_kind_t int_kind_reg;
  int_kind_t int_kind_next;
  logic [IDX_W-1:0] int_index_reg;
  logic [IDX_W-1:0] int_index_next;

  // Source events
  logic [NUM_EXT_PINS-1:0] ext_edge;
  logic key_edge;
  logic [NUM_MASKABLE-1:0] src_event;
  logic access;
  logic addr_ok;
  logic write_fire;
  logic ack_fire;
  logic [31:0] status_word;

  always_comb begin
    ext_edge = (EXT_PIN & ~ext_prev_reg & rise_en_reg)
               | (~EXT_PIN & ext_prev_reg & fall_en_reg);
    key_edge = |(key_prev_reg & ~KEY_PIN);
    // Source order equals default priority, index 0 first
    src_event = {key_edge, WATCH_OVERFLOW, ADC_DONE, TIMER8B_MATCH, TIMER8A_MATCH,
                 TIMER16_MATCH[1], TIMER16_MATCH[0], WATCH_INTERVAL, TWO_WIRE_DONE,
                 THREE_WIRE_DONE, ASYNC_TX_DONE, ASYNC_RX_DONE, ASYNC_RX_ERROR,
                 ext_edge, WATCHDOG_OVERFLOW & ~wdt_nmi_reg};
  end

  always_comb begin
    sel.req = req_reg;
    sel.mask = mask_reg;
    sel.prio = prio_reg;
    sel.ie = global_enable_flag_reg;
    sel.in_service_level_flag = in_service_level_flag_reg;
  end

  irq_priority_resolver u_resolver (
    .sel(sel.resolver)
  );

  // APB decode
  always_comb begin
    access = PSEL & PENABLE;
    addr_ok = (PADDR[1:0] == 2'b00) && (PADDR <= OFS_STATUS);
    write_fire = access & pready_reg & PWRITE & addr_ok;
    ack_fire = INT_ACK & int_req_reg;
    status_word = '0;
    status_word[STAT_INDEX_LSB +: IDX_W] = sel.index;
    status_word[STAT_MASKABLE_BIT] = sel.valid;
    status_word[STAT_NMI_BIT] = nmi_pend_reg;
    status_word[STAT_TRAP_BIT] = trap_pend_reg;
    status_word[STAT_KIND_LSB +: 2] = int_kind_reg;
  end

  always_comb begin
    pready_next = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~addr_ok;
    prdata_next = '0;
    if (access && !pready_reg && !PWRITE) begin
      case (PADDR)
        OFS_REQ: prdata_next[NUM_MASKABLE-1:0] = req_reg;
        OFS_MASK: prdata_next[NUM_MASKABLE-1:0] = mask_reg;
        OFS_PRIO: prdata_next[NUM_MASKABLE-1:0] = prio_reg;
        OFS_CTRL: begin
          prdata_next[CTRL_IE_BIT] = global_enable_flag_reg;
          prdata_next[CTRL_ISP_BIT] = in_service_level_flag_reg;
          prdata_next[CTRL_WDT_NMI_BIT] = wdt_nmi_reg;
        end
        OFS_EDGE: begin
          prdata_next[EDGE_RISE_LSB +: NUM_EXT_PINS] = rise_en_reg;
          prdata_next[EDGE_FALL_LSB +: NUM_EXT_PINS] = fall_en_reg;
        end
        OFS_STATUS: prdata_next = status_word;
        default: prdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Flag and control next values
  always_comb begin
    req_next = req_reg;
    mask_next = mask_reg;
    prio_next = prio_reg;
    global_enable_flag_next = global_enable_flag_reg;
    in_service_level_flag_next = in_service_level_flag_reg;
    wdt_nmi_next = wdt_nmi_reg;
    nmi_pend_next = nmi_pend_reg;
    trap_pend_next = trap_pend_reg;
    rise_en_next = rise_en_reg;
    fall_en_next = fall_en_reg;
    if (write_fire) begin
      case (PADDR)
        OFS_REQ: req_next = req_reg & ~PWDATA[NUM_MASKABLE-1:0];
        OFS_MASK: mask_next = PWDATA[NUM_MASKABLE-1:0];
        OFS_PRIO: prio_next = PWDATA[NUM_MASKABLE-1:0];
        OFS_CTRL: begin
          global_enable_flag_next = PWDATA[CTRL_IE_BIT];
          in_service_level_flag_next = PWDATA[CTRL_ISP_BIT];
          wdt_nmi_next = PWDATA[CTRL_WDT_NMI_BIT];
        end
        OFS_EDGE: begin
          rise_en_next = PWDATA[EDGE_RISE_LSB +: NUM_EXT_PINS];
          fall_en_next = PWDATA[EDGE_FALL_LSB +: NUM_EXT_PINS];
        end
        default: req_next = req_reg;
      endcase
    end
    if (INT_RETURN) begin
      global_enable_flag_next = RESTORE_IE;
      in_service_level_flag_next = RESTORE_ISP;
    end
    if (ack_fire) begin
      global_enable_flag_next = 1'b0;
      case (int_kind_reg)
        KIND_NMI: nmi_pend_next = 1'b0;
        KIND_TRAP: trap_pend_next = 1'b0;
        KIND_MASKABLE: begin
          req_next[int_index_reg] = 1'b0;
          in_service_level_flag_next = prio_reg[int_index_reg];
        end
        default: nmi_pend_next = nmi_pend_reg;
      endcase
    end
    // New events win over any clear in the same cycle
    req_next = req_next | src_event;
    if (WATCHDOG_OVERFLOW && wdt_nmi_reg) begin
      nmi_pend_next = 1'b1;
    end
    if (SOFTWARE_TRAP_INSTRUCTION) begin
      trap_pend_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_reg <= REQ_RESET;
      mask_reg <= MASK_RESET;
      prio_reg <= PRIO_RESET;
      global_enable_flag_reg <= CTRL_IE_RESET;
      in_service_level_flag_reg <= CTRL_ISP_RESET;
      wdt_nmi_reg <= CTRL_WDT_NMI_RESET;
      nmi_pend_reg <= 1'b0;
      trap_pend_reg <= 1'b0;
      rise_en_reg <= EDGE_RESET;
      fall_en_reg <= EDGE_RESET;
      ext_prev_reg <= '0;
      key_prev_reg <= '1;
    end else begin
      req_reg <= req_next;
      mask_reg <= mask_next;
      prio_reg <= prio_next;
      global_enable_flag_reg <= global_enable_flag_next;
      in_service_level_flag_reg <= in_service_level_flag_next;
      wdt_nmi_reg <= wdt_nmi_next;
      nmi_pend_reg <= nmi_pend_next;
      trap_pend_reg <= trap_pend_next;
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      ext_prev_reg <= EXT_PIN;
      key_prev_reg <= KEY_PIN;
    end
  end

  // Request presented to the CPU: NMI, then trap, then maskable winner
  always_comb begin
    int_req_next = 1'b0;
    int_kind_next = KIND_NONE;
    int_vector_next = '0;
    int_index_next = '0;
    if (ack_fire) begin
      int_req_next = 1'b0;
    end else if (nmi_pend_reg) begin
      int_req_next = 1'b1;
      int_kind_next = KIND_NMI;
      int_vector_next = WDT_VECTOR;
    end else if (trap_pend_reg) begin
      int_req_next = 1'b1;
      int_kind_next = KIND_TRAP;
      int_vector_next = VECTOR_TRAP;
    end else if (sel.valid) begin
      int_req_next = 1'b1;
      int_kind_next = KIND_MASKABLE;
      int_index_next = sel.index;
      int_vector_next = (sel.index == '0) ? WDT_VECTOR : VECTOR_TABLE[sel.index];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      int_req_reg <= 1'b0;
      int_kind_reg <= KIND_NONE;
      int_vector_reg <= '0;
      int_index_reg <= '0;
    end else begin
      int_req_reg <= int_req_next;
      int_kind_reg <= int_kind_next;
      int_vector_reg <= int_vector_next;
      int_index_reg <= int_index_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign INT_REQ = int_req_reg;
  assign INT_VECTOR = int_vector_reg;
  assign INT_KIND = int_kind_reg;
  assign GLOBAL_ENABLE = global_enable_flag_reg;

endmodule

// ### sim/vic_properties.sv
// Port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vic_properties import vic_pkg::*; #(
  parameter logic [15:0] WDT_VECTOR = 16'h0004
) (
  // Clock and reset
  input logic MCLK,
  input logic RST_N,
  // APB
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [APB_ADDR_W-1:0] PADDR,
  input logic [31:0] PWDATA,
  input logic PREADY,
  input logic PSLVERR,
  // Events and CPU side
  input logic WATCHDOG_OVERFLOW,
  input logic SOFTWARE_TRAP_INSTRUCTION,
  input logic INT_ACK,
  input logic INT_REQ,
  input logic [15:0] INT_VECTOR,
  input logic [1:0] INT_KIND,
  input logic GLOBAL_ENABLE
);
  logic nmi_mode_reg;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Watchdog mode as last written
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      nmi_mode_reg <= CTRL_WDT_NMI_RESET;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_CTRL)
      nmi_mode_reg <= PWDATA[CTRL_WDT_NMI_BIT];
  end
  nmi_vector_a: assert property (INT_REQ && INT_KIND == 2'd1 |-> INT_VECTOR == WDT_VECTOR)
    else $error("nmi vector wrong");
  nmi_forward_a: assert property (WATCHDOG_OVERFLOW && nmi_mode_reg
    |-> ##[1:6] (INT_REQ && INT_KIND == 2'd1)) else $error("nmi not presented");
  nmi_mode_a: assert property ($rose(INT_REQ) && INT_KIND == 2'd1 |-> nmi_mode_reg)
    else $error("nmi outside watchdog mode");
  trap_vector_a: assert property (INT_REQ && INT_KIND == 2'd3 |-> INT_VECTOR == 16'h003e)
    else $error("trap vector wrong");
  trap_forward_a: assert property (SOFTWARE_TRAP_INSTRUCTION
    |-> ##[1:12] (INT_REQ && INT_KIND == 2'd3)) else $error("trap not presented");
  maskable_vec_a: assert property (INT_REQ && INT_KIND == 2'd2 |-> !INT_VECTOR[0]
    && INT_VECTOR inside {[16'h0004:16'h0028]} && INT_VECTOR != 16'h0018)
    else $error("maskable vector wrong");
  enable_gate_a: assert property ($rose(INT_REQ) && INT_KIND == 2'd2
    |-> GLOBAL_ENABLE || $past(GLOBAL_ENABLE)) else $error("maskable while disabled");
  ack_clear_a: assert property (INT_ACK && INT_REQ |=> !INT_REQ && !GLOBAL_ENABLE)
    else $error("ack did not drop request");
  cover property (INT_REQ && INT_KIND == 2'd1);
  cover property (INT_REQ && INT_KIND == 2'd3);
  cover property (INT_REQ && INT_VECTOR == 16'h0028);
  cover property (PREADY && PSLVERR);
endmodule

bind vectored_interrupt_controller vic_properties #(.WDT_VECTOR(WDT_VECTOR)) i_props (
  .MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR,
  .WATCHDOG_OVERFLOW, .SOFTWARE_TRAP_INSTRUCTION, .INT_ACK, .INT_REQ, .INT_VECTOR,
  .INT_KIND, .GLOBAL_ENABLE);

// ### sim/cpu_core_model.sv
// Behavioural CPU core that takes and returns from interrupts
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Controller side
  input logic slow,
  input logic int_req,
  input logic [15:0] int_vector,
  input logic [1:0] int_kind,
  input logic global_enable,
  output logic int_ack,
  output logic int_return,
  output logic restore_ie,
  output logic restore_isp,
  // Taken vector report
  output logic got,
  output logic [15:0] got_vec,
  output logic [1:0] got_kind
);
  int busy;
  assign restore_isp = 1'b1;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {int_ack, int_return, restore_ie, got, got_vec, got_kind} <= '0;
      busy <= 0;
    end else begin
      int_ack <= 1'b0;
      int_return <= 1'b0;
      got <= 1'b0;
      if (int_ack) begin
        got <= int_req;
        got_vec <= int_vector;
        got_kind <= int_kind;
        restore_ie <= global_enable;
        busy <= int_req ? (slow ? 6 : 2) : 0;
      end else if (busy > 0) begin
        busy <= busy - 1;
        int_return <= (busy == 1);
      end else if (int_req) begin
        int_ack <= 1'b1;
      end
    end
  end
endmodule

// ### sim/vectored_interrupt_controller_tb_top.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vectored_interrupt_controller_tb_top import vic_pkg::*; ;
  localparam logic [15:0] WDT_VEC = 16'h0004;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, trap = 0, slow = 0;
  logic [7:0] paddr = '0, key_pin = 8'hff;
  logic [31:0] pwdata = '0, prdata;
  logic [17:0] src = '0;
  logic [3:0] ext_pin = '0;
  logic pready, pslverr, int_ack, int_ret, rest_ie, rest_isp, int_req, gie, got;
  logic [15:0] int_vec, got_vec;
  logic [1:0] int_kind, got_kind;
  logic [17:0] exp_q[$];
  logic [15:0] vtab[18] = '{WDT_VEC, 16'h6, 16'h8, 16'ha, 16'hc, 16'he, 16'h10, 16'h12,
    16'h14, 16'h16, 16'h1a, 16'h1c, 16'h1e, 16'h20, 16'h22, 16'h24, 16'h26, 16'h28};
  int error_cnt = 0, n_checks = 0;
  always #2 mclk = ~mclk;
  vectored_interrupt_controller #(.WDT_VECTOR(WDT_VEC)) i_dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .WATCHDOG_OVERFLOW(src[0]), .EXT_PIN(ext_pin), .ASYNC_RX_ERROR(src[5]),
    .ASYNC_RX_DONE(src[6]), .ASYNC_TX_DONE(src[7]), .THREE_WIRE_DONE(src[8]),
    .TWO_WIRE_DONE(src[9]), .WATCH_INTERVAL(src[10]), .TIMER16_MATCH(src[12:11]),
    .TIMER8A_MATCH(src[13]), .TIMER8B_MATCH(src[14]), .ADC_DONE(src[15]),
    .WATCH_OVERFLOW(src[16]), .KEY_PIN(key_pin), .SOFTWARE_TRAP_INSTRUCTION(trap),
    .INT_ACK(int_ack), .INT_RETURN(int_ret), .RESTORE_IE(rest_ie), .RESTORE_ISP(rest_isp),
    .INT_REQ(int_req), .INT_VECTOR(int_vec), .INT_KIND(int_kind), .GLOBAL_ENABLE(gie));
  cpu_core_model i_cpu (.clk(mclk), .rst_n(rst_n), .slow(slow), .int_req(int_req),
    .int_vector(int_vec), .int_kind(int_kind), .global_enable(gie), .int_ack(int_ack),
    .int_return(int_ret), .restore_ie(rest_ie), .restore_isp(rest_isp), .got(got),
    .got_vec(got_vec), .got_kind(got_kind));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    chk("pready seen", 32'h1, {31'h0, pready});
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read data", x, q);
    chk("read error", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic fire(input logic [17:0] m, input logic t);
    @(posedge mclk);
    src <= m;
    ext_pin <= m[4:1];
    key_pin <= m[17] ? ~(8'h1 << $urandom_range(7)) : 8'hff;
    trap <= t;
    @(posedge mclk);
    src <= '0;
    ext_pin <= '0;
    key_pin <= 8'hff;
    trap <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("pending vectors", 32'h0, exp_q.size());
    exp_q.delete();
    repeat (10) @(posedge mclk);
  endtask
  // Every vector the core takes is compared with the model queue
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      chk("vector", exp_q.size() != 0 ? {14'h0, exp_q[0]} : '1, {got_kind, got_vec});
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    int i;
    int j;
    logic [17:0] m;
    void'($urandom(32'hc026));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_REQ, 32'h0, 1'b0);
    rd(OFS_MASK, 32'h3ffff, 1'b0);
    rd(OFS_PRIO, 32'h3ffff, 1'b0);
    rd(OFS_CTRL, 32'h6, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    $display("test reset and refusal done");
    wr(OFS_MASK, 32'h0);
    wr(OFS_EDGE, 32'hf);
    wr(OFS_CTRL, 32'h3);
    for (i = 0; i < 18; i++) begin
      exp_q.push_back({2'd2, vtab[i]});
      fire(18'h1 << i, 1'b0);
      drain;
    end
    $display("test single sources done");
    wr(OFS_EDGE, 32'hf0);
    rd(OFS_EDGE, 32'hf0, 1'b0);
    for (i = 1; i < 5; i++) begin
      exp_q.push_back({2'd2, vtab[i]});
      fire(18'h1 << i, 1'b0);
      drain;
    end
    wr(OFS_EDGE, 32'hf);
    $display("test falling edges done");
    slow <= 1'b1;
    repeat (3) begin
      m = 18'($urandom);
      j = $urandom_range(17);
      m[j] = 1'b1;
      wr(OFS_CTRL, 32'h2);
      wr(OFS_PRIO, 32'h3ffff ^ (32'h1 << j));
      fire(m, 1'b0);
      rd(OFS_REQ, {14'h0, m}, 1'b0);
      exp_q.push_back({2'd2, vtab[j]});
      for (i = 0; i < 18; i++)
        if (m[i] && i != j) exp_q.push_back({2'd2, vtab[i]});
      wr(OFS_CTRL, 32'h3);
      drain;
    end
    $display("test priority done");
    wr(OFS_PRIO, 32'h3ffff);
    wr(OFS_MASK, 32'h80);
    fire(18'h80, 1'b0);
    repeat (8) @(posedge mclk);
    rd(OFS_REQ, 32'h80, 1'b0);
    rd(OFS_STATUS, 32'h0, 1'b0);
    wr(OFS_REQ, 32'h80);
    rd(OFS_REQ, 32'h0, 1'b0);
    wr(OFS_MASK, 32'h0);
    $display("test mask done");
    wr(OFS_CTRL, 32'h6);
    exp_q.push_back({2'd1, WDT_VEC});
    exp_q.push_back({2'd3, 16'h3e});
    fire(18'h8001, 1'b1);
    drain;
    rd(OFS_REQ, 32'h8000, 1'b0);
    exp_q.push_back({2'd2, 16'h24});
    wr(OFS_CTRL, 32'h7);
    drain;
    $display("test nmi and trap done");
    end_sim;
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
endmodule
